// ===== core/psr_params.svh
// Timing constants for the processor supervisor and reset controller.
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// ----------------------------------------
// Clock rate
// ----------------------------------------
`define PSR_CLK_HZ 100000000

// ----------------------------------------
// Times in their own units, plus the early-warning sample count
// ----------------------------------------
`define PSR_POR_HOLD_MS 100
`define PSR_RST_HOLD_MS 25
`define PSR_WDOG_MS 400
`define PSR_DEBOUNCE_MS 10
`define PSR_NMI_PULSE_US 200
`define PSR_SAMPLE_US 33
`define PSR_EW_SAMPLES 3

// ----------------------------------------
// Derived cycle counts
// ----------------------------------------
`define PSR_POR_HOLD_CYC (`PSR_POR_HOLD_MS * (`PSR_CLK_HZ / 1000))
`define PSR_RST_HOLD_CYC (`PSR_RST_HOLD_MS * (`PSR_CLK_HZ / 1000))
`define PSR_WDOG_CYC (`PSR_WDOG_MS * (`PSR_CLK_HZ / 1000))
`define PSR_DEBOUNCE_CYC (`PSR_DEBOUNCE_MS * (`PSR_CLK_HZ / 1000))
`define PSR_NMI_PULSE_CYC (`PSR_NMI_PULSE_US * (`PSR_CLK_HZ / 1000000))
`define PSR_SAMPLE_CYC (`PSR_SAMPLE_US * (`PSR_CLK_HZ / 1000000))

`endif

// ===== core/psr_pkg.sv
// Types shared by the supervisor and reset controller modules.
package psr_pkg;

	typedef enum logic [3:0] {
		PSR_S_OFF  = 4'b0001,
		PSR_S_HOLD = 4'b0010,
		PSR_S_RUN  = 4'b0100,
		PSR_S_BTN  = 4'b1000
	} psr_state_t;

	typedef struct packed {
		psr_state_t fsm;
		logic [31:0] wd_cnt;
		logic [31:0] deb_cnt;
		logic [31:0] smp_cnt;
		logic [1:0] low_cnt;
		logic btn_db;
		logic strobe_prev;
		logic sup_prev;
		logic nmi_done;
		logic rst;
		logic rst_n;
		logic pf;
		logic pf_n;
		logic sram_n;
		logic nmi_n;
		logic sleep;
	} psr_main_t;

endpackage

// ===== core/psr_tmr_if.sv
// Load and busy handshake between the controller and a countdown timer.
`timescale 1ns/1ps
interface psr_tmr_if;
	logic load;
	logic [31:0] count;
	logic busy;
	modport ctl (output load, output count, input busy);
	modport tmr (input load, input count, output busy);
endinterface

// ===== core/psr_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module psr_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Data
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} psr_sync_st_t;

	psr_sync_st_t q_r;
	psr_sync_st_t q_nxt;

	// ----------------------------------------
	// Per-bit stages
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			always_comb begin
				q_nxt.s1[gi] = i_async[gi];
				q_nxt.s2[gi] = q_r.s1[gi];
			end
		end
	endgenerate

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign o_sync = q_r.s2;
endmodule

// ===== core/psr_timer.sv
// Countdown timer that stays busy for a loaded number of cycles.
`timescale 1ns/1ps
module psr_timer (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Control
	psr_tmr_if.tmr tif
);
	typedef struct packed {
		logic [31:0] cnt;
	} psr_tmr_st_t;

	psr_tmr_st_t q_r;
	psr_tmr_st_t q_nxt;

	always_comb begin
		q_nxt = q_r;
		if (tif.load) begin
			q_nxt.cnt = tif.count;
		end else if (q_r.cnt != 32'h0) begin
			q_nxt.cnt = q_r.cnt - 32'h1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Busy comes from the counter alone, so a caller may test it while deciding to load without a loop.
	assign tif.busy = (q_r.cnt != 32'h0);

	property p_tmr_load;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		tif.load |=> (q_r.cnt == $past(tif.count));
	endproperty
	a_tmr_load: assert property (p_tmr_load) else $error("timer did not take its load value"); // RL21
endmodule

// ===== core/psr_supervisor.sv
// Supervisor: supply reset, watchdog, pushbutton, early-warning interrupt and SRAM guard.
//
// Contract
// RL1 - Supply failure drives both reset outputs active.
// RL2 - Hold reset after supply returns, long enough.
// RL3 - Supply failure drives both power-fail outputs active.
// RL4 - Supply failure blocks the SRAM chip enable.
// RL5 - Power-fail high and low outputs agree.
// RL6 - Reset high and low outputs always agree.
// RL7 - Mode input selects CMOS or NMOS behaviour.
// RL8 - CMOS mode: no reset on power-down.
// RL9 - CMOS mode: pulsed interrupt warns of loss.
// RL10 - CMOS mode: still give power-on reset.
// RL11 - NMOS mode: notify, then reset while supply lost. The code starts the interrupt and the reset in the same cycle.
// RL12 - NMOS mode: reset until supply reaches trip.
// RL13 - Early-warning input raises the interrupt.
// RL14 - Debounced button press drives reset active.
// RL15 - Watchdog expiry drives reset active.
// RL16 - Strobe falling edge restarts the watchdog.
// RL17 - Sleep control enters and leaves low power.
// RL18 - Watchdog period, start point, expiry reset length.
// RL19 - Button reset lasts past release.
// RL20 - Three low samples; interrupt pulse length.
// RL21 - Timebase counts; inputs synchronised first.
`timescale 1ns/1ps
`include "psr_params.svh"
module psr_supervisor import psr_pkg::*; #(
	parameter int unsigned POR_HOLD_CYC = `PSR_POR_HOLD_CYC,
	parameter int unsigned RST_HOLD_CYC = `PSR_RST_HOLD_CYC,
	parameter int unsigned WDOG_CYC = `PSR_WDOG_CYC,
	parameter int unsigned DEBOUNCE_CYC = `PSR_DEBOUNCE_CYC,
	parameter int unsigned NMI_PULSE_CYC = `PSR_NMI_PULSE_CYC
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Comparator results
	input wire logic i_supply_ok,
	input wire logic i_early_warn_low,
	// Configuration and processor pins
	input wire logic i_reset_mode_sel,
	input wire logic i_watchdog_strobe_n,
	input wire logic i_button_reset_in_n,
	input wire logic i_sleep_wake_ctrl_n,
	input wire logic i_sram_enable_in_n,
	// Reset and power-fail outputs
	output logic o_rst,
	output logic o_rst_n,
	output logic o_power_fail_out,
	output logic o_power_fail_out_n,
	// Memory guard, interrupt, sleep
	output logic o_sram_enable_out_n,
	output logic o_nmi_n,
	output logic o_sleep_mode
);
	localparam logic [31:0] SAMPLE_CYC = 32'(`PSR_SAMPLE_CYC);
	localparam logic [1:0] EW_LAST = 2'(`PSR_EW_SAMPLES - 1);

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	logic [6:0] sync_v;
	logic sup_ok;
	logic ew_low;
	logic mode_cmos;
	logic strobe_n;
	logic button_n;
	logic sleep_req;
	logic sram_in_n;

	// RL21 synchronise all pins
	psr_sync #(.W(7)) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_async({i_supply_ok, i_early_warn_low, i_reset_mode_sel, i_watchdog_strobe_n,
			i_button_reset_in_n, ~i_sleep_wake_ctrl_n, i_sram_enable_in_n}),
		.o_sync(sync_v)
	);

	assign sup_ok = sync_v[6];
	assign ew_low = sync_v[5];
	assign mode_cmos = sync_v[4];
	assign strobe_n = sync_v[3];
	assign button_n = sync_v[2];
	assign sleep_req = sync_v[1];
	assign sram_in_n = sync_v[0];

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	psr_tmr_if hold_if ();
	psr_tmr_if nmi_if ();

	psr_timer u_hold_tmr (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.tif(hold_if.tmr)
	);

	psr_timer u_nmi_tmr (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.tif(nmi_if.tmr)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	psr_main_t q_r;
	psr_main_t q_nxt;
	logic hold_load;
	logic [31:0] hold_count;
	logic nmi_load;
	logic strobe_fall;
	logic tick;
	logic wd_off;
	logic btn_off;
	logic wd_expire;

	assign hold_if.load = hold_load;
	assign hold_if.count = hold_count;
	assign nmi_if.load = nmi_load;
	assign nmi_if.count = 32'(NMI_PULSE_CYC);

	always_comb begin
		q_nxt = q_r;
		hold_load = 1'b0;
		hold_count = 32'(RST_HOLD_CYC);
		nmi_load = 1'b0;
		wd_expire = 1'b0;
		q_nxt.strobe_prev = strobe_n;
		q_nxt.sup_prev = sup_ok;
		strobe_fall = q_r.strobe_prev & ~strobe_n;
		// RL7 mode decoded from static input
		wd_off = mode_cmos & ew_low;
		btn_off = mode_cmos & ew_low;

		// RL17 sleep follows the control input
		q_nxt.sleep = sleep_req;

		// RL14 debounce the pushbutton level
		if ((~button_n) != q_r.btn_db && !btn_off) begin
			if (q_r.deb_cnt >= 32'(DEBOUNCE_CYC) - 32'h1) begin
				q_nxt.btn_db = ~button_n;
				q_nxt.deb_cnt = 32'h0;
			end else begin
				q_nxt.deb_cnt = q_r.deb_cnt + 32'h1;
			end
		end else begin
			q_nxt.deb_cnt = 32'h0;
		end
		if (btn_off) begin
			q_nxt.btn_db = 1'b0;
		end

		// RL20 periodic early-warning sampling
		tick = (q_r.smp_cnt == SAMPLE_CYC - 32'h1);
		q_nxt.smp_cnt = tick ? 32'h0 : q_r.smp_cnt + 32'h1;
		if (q_r.sleep) begin
			q_nxt.smp_cnt = 32'h0;
			tick = 1'b0;
		end
		if (tick) begin
			if (!ew_low) begin
				q_nxt.low_cnt = 2'h0;
			end else if (q_r.low_cnt != EW_LAST) begin
				q_nxt.low_cnt = q_r.low_cnt + 2'h1;
			end
		end
		if (!ew_low) begin
			q_nxt.nmi_done = 1'b0;
		end

		// RL13 early warning fires the interrupt after the third low sample
		if (tick && ew_low && q_r.low_cnt == EW_LAST && sup_ok && !q_r.nmi_done) begin
			nmi_load = 1'b1;
			q_nxt.nmi_done = 1'b1;
		end
		// Strobing while below the warning level echoes an interrupt back.
		if (strobe_fall && ew_low && sup_ok && !nmi_if.busy) begin
			nmi_load = 1'b1;
		end
		// RL11 notify the processor as the supply fails in NMOS mode
		if (q_r.sup_prev && !sup_ok && !mode_cmos && !nmi_if.busy) begin
			nmi_load = 1'b1;
		end

		// RL16 watchdog counts only while running and restarts on a strobe edge
		if (q_r.fsm == PSR_S_RUN && !wd_off && !q_r.sleep) begin
			if (strobe_fall) begin
				q_nxt.wd_cnt = 32'h0;
			end else if (q_r.wd_cnt >= 32'(WDOG_CYC) - 32'h1) begin
				wd_expire = 1'b1;
				q_nxt.wd_cnt = 32'h0;
			end else begin
				q_nxt.wd_cnt = q_r.wd_cnt + 32'h1;
			end
		end else begin
			q_nxt.wd_cnt = 32'h0;
		end

		unique case (q_r.fsm)
			PSR_S_OFF: begin
				// RL12 leave only once the supply is back at trip level
				if (sup_ok) begin
					// RL2 power-on hold
					// RL10 also in CMOS mode
					hold_load = 1'b1;
					hold_count = 32'(POR_HOLD_CYC);
					q_nxt.fsm = PSR_S_HOLD;
				end
			end
			PSR_S_HOLD: begin
				if (!hold_if.busy) begin
					q_nxt.fsm = PSR_S_RUN;
				end
			end
			PSR_S_RUN: begin
				if (q_r.btn_db) begin
					q_nxt.fsm = PSR_S_BTN;
				end else if (wd_expire) begin
					// RL15 expiry forces reset
					// RL18 expiry reset length
					hold_load = 1'b1;
					q_nxt.fsm = PSR_S_HOLD;
				end
			end
			PSR_S_BTN: begin
				// RL19 hold timed from release
				if (!q_r.btn_db) begin
					hold_load = 1'b1;
					q_nxt.fsm = PSR_S_HOLD;
				end
			end
		endcase
		if (!sup_ok) begin
			q_nxt.fsm = PSR_S_OFF;
			hold_load = 1'b0;
		end

		// RL1 reset whenever not running, except the CMOS power-down case
		// RL8 CMOS mode keeps reset off during supply loss
		q_nxt.rst = (q_nxt.fsm != PSR_S_RUN) && !(q_nxt.fsm == PSR_S_OFF && mode_cmos);
		q_nxt.rst_n = ~q_nxt.rst;
		// RL3 power-fail follows the supply comparator
		q_nxt.pf = ~sup_ok;
		q_nxt.pf_n = ~q_nxt.pf;
		// RL4 unconditional SRAM write protection
		q_nxt.sram_n = ~sup_ok | sram_in_n;
		// RL9 interrupt pulse while its timer runs
		q_nxt.nmi_n = ~(nmi_load | nmi_if.busy);
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q_r <= '{fsm: PSR_S_OFF, rst: 1'b1, pf: 1'b1, sram_n: 1'b1, nmi_n: 1'b1, default: '0};
		end else begin
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// RL6 complementary resets from paired flops
	assign o_rst = q_r.rst;
	assign o_rst_n = q_r.rst_n;
	// RL5 complementary power-fail from paired flops
	assign o_power_fail_out = q_r.pf;
	assign o_power_fail_out_n = q_r.pf_n;
	assign o_sram_enable_out_n = q_r.sram_n;
	assign o_nmi_n = q_r.nmi_n;
	assign o_sleep_mode = q_r.sleep;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_rst_fail;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(!sup_ok && !mode_cmos) |=> o_rst;
	endproperty
	a_rst_fail: assert property (p_rst_fail) else $error("reset not active on supply failure"); // RL1

	property p_por_hold;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(q_r.fsm == PSR_S_OFF && sup_ok) |=> (o_rst && !o_rst_n) [*8];
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("power-on reset released too early"); // RL2

	property p_pf;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!sup_ok |=> (o_power_fail_out && !o_power_fail_out_n);
	endproperty
	a_pf: assert property (p_pf) else $error("power-fail outputs not active"); // RL3

	property p_sram;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!sup_ok |=> o_sram_enable_out_n;
	endproperty
	a_sram: assert property (p_sram) else $error("SRAM enable passed during supply failure"); // RL4

	property p_pf_pair;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_power_fail_out != o_power_fail_out_n;
	endproperty
	a_pf_pair: assert property (p_pf_pair) else $error("power-fail outputs disagree"); // RL5

	property p_rst_pair;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_rst != o_rst_n;
	endproperty
	a_rst_pair: assert property (p_rst_pair) else $error("reset outputs disagree"); // RL6

	property p_cmos_down;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(!sup_ok && mode_cmos) |=> !o_rst;
	endproperty
	a_cmos_down: assert property (p_cmos_down) else $error("reset asserted on CMOS power-down"); // RL8

	property p_nmi_pulse;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		nmi_load |=> !o_nmi_n [*8];
	endproperty
	a_nmi_pulse: assert property (p_nmi_pulse) else $error("interrupt pulse too short"); // RL13

	property p_wd_restart;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(strobe_fall && q_r.fsm == PSR_S_RUN) |=> (q_r.wd_cnt == 32'h0);
	endproperty
	a_wd_restart: assert property (p_wd_restart) else $error("strobe edge did not restart watchdog"); // RL16

	property p_wd_reset;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(wd_expire && sup_ok) |=> o_rst;
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("watchdog expiry gave no reset"); // RL15

	property p_sleep;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		$rose(sleep_req) |=> o_sleep_mode;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep mode not entered"); // RL17

	property p_ew_three;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(tick && q_r.low_cnt != EW_LAST && !strobe_fall && !(q_r.sup_prev && !sup_ok && !mode_cmos)) |-> !nmi_load;
	endproperty
	a_ew_three: assert property (p_ew_three) else $error("interrupt fired before the third low sample"); // RL20
endmodule

// ===== tb/psr_host_model.sv
// Host processor model: periodic watchdog strobes and SRAM chip enable.
`timescale 1ns/1ps
module psr_host_model #(
	parameter int STROBE_GAP = 20
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Control from the bench and the supervisor
	input wire logic i_en,
	input wire logic i_rst,
	// Pins towards the supervisor
	output logic o_watchdog_strobe_n,
	output logic o_sram_enable_in_n
);
	int cnt;

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt <= 0;
			o_watchdog_strobe_n <= 1'b1;
			o_sram_enable_in_n <= 1'b1;
		end else begin
			o_sram_enable_in_n <= ~i_en;
			if (!i_en || i_rst) begin
				cnt <= 0;
				o_watchdog_strobe_n <= 1'b1;
			end else if (cnt == STROBE_GAP - 1) begin
				cnt <= 0;
				o_watchdog_strobe_n <= 1'b0;
			end else begin
				cnt <= cnt + 1;
				if (cnt == 1) begin
					o_watchdog_strobe_n <= 1'b1;
				end
			end
		end
	end
endmodule

// ===== tb/psr_supervisor_tb.sv
// Self-checking bench for the supervisor and reset controller.
`timescale 1ns/1ps
module psr_supervisor_tb import psr_pkg::*; ;
	localparam int POR = 40;
	localparam int RH = 20;
	localparam int WD = 60;
	localparam int DB = 5;
	localparam int NP = 10;
	logic clk, rst, sup_ok, ew_low, mode, btn_n, sleep_n, host_en;
	wire logic strobe_n, sram_in_n;
	wire logic o_rst, o_rst_n, pf, pf_n, sram_out_n, o_nmi_n, o_sleep_mode;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	int n;

	psr_supervisor #(.POR_HOLD_CYC(POR), .RST_HOLD_CYC(RH), .WDOG_CYC(WD), .DEBOUNCE_CYC(DB),
		.NMI_PULSE_CYC(NP)) DUT (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_supply_ok(sup_ok), .i_early_warn_low(ew_low),
		.i_reset_mode_sel(mode), .i_watchdog_strobe_n(strobe_n), .i_button_reset_in_n(btn_n),
		.i_sleep_wake_ctrl_n(sleep_n), .i_sram_enable_in_n(sram_in_n), .o_rst(o_rst), .o_rst_n(o_rst_n),
		.o_power_fail_out(pf), .o_power_fail_out_n(pf_n), .o_sram_enable_out_n(sram_out_n),
		.o_nmi_n(o_nmi_n), .o_sleep_mode(o_sleep_mode));

	psr_host_model #(.STROBE_GAP(20)) host (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_en(host_en), .i_rst(o_rst),
		.o_watchdog_strobe_n(strobe_n), .o_sram_enable_in_n(sram_in_n));

	initial clk = 1'b0;
	always #5 clk = ~clk;

	// ----------------------------------------
	// Checking and waiting
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ok(input logic c);
		check({31'h0, c}, 32'h1);
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return o_rst;
			1: return o_nmi_n;
			default: return o_sleep_mode;
		endcase
	endfunction

	// Counts edges until the chosen output shows the level, up to a limit.
	task automatic wait_sig(input int sel, input logic lvl, input int max, output int cnt);
		cnt = 0;
		while (pick(sel) !== lvl && cnt < max) begin
			@(posedge clk);
			#1;
			cnt++;
		end
	endtask

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			stop_test;
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		sup_ok = 1'b1;
		ew_low = 1'b0;
		mode = 1'b0;
		btn_n = 1'b1;
		sleep_n = 1'b1;
		host_en = 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		check({o_rst, o_rst_n}, 32'h2);
		wait_sig(0, 1'b0, POR + 30, n);
		ok(n >= POR && n <= POR + 10);
		check({pf, pf_n}, 32'h1);
		$display("power-on test done");

		host_en <= 1'b1;
		wait_sig(0, 1'b1, 300, n);
		check(n, 300);
		host_en <= 1'b0;
		wait_sig(0, 1'b1, WD + 10, n);
		ok(n >= WD - 25 && n < WD + 10);
		check(o_rst_n, 1'b0);
		wait_sig(0, 1'b0, RH + 20, n);
		ok(n >= RH);
		host_en <= 1'b1;
		$display("watchdog test done");

		btn_n <= 1'b0;
		wait_sig(0, 1'b1, DB + 10, n);
		ok(n >= DB && n < DB + 10);
		wait_sig(0, 1'b0, 50, n);
		check(n, 50);
		btn_n <= 1'b1;
		wait_sig(0, 1'b0, RH + DB + 15, n);
		ok(n >= RH + DB);
		$display("button test done");

		repeat (5) @(posedge clk);
		#1;
		check(sram_out_n, 1'b0);
		sup_ok <= 1'b0;
		wait_sig(1, 1'b0, 10, n);
		ok(n <= 5);
		repeat (3) @(posedge clk);
		#1;
		check({o_rst, o_rst_n, pf, pf_n, sram_out_n}, 32'h15);
		wait_sig(0, 1'b0, 100, n);
		check(n, 100);
		sup_ok <= 1'b1;
		wait_sig(0, 1'b0, POR + 20, n);
		ok(n >= POR);
		check({pf, sram_out_n}, 32'h0);
		$display("nmos supply test done");

		mode <= 1'b1;
		repeat (5) @(posedge clk);
		sup_ok <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
		check({o_rst, pf, sram_out_n, o_nmi_n}, 32'h7);
		sup_ok <= 1'b1;
		wait_sig(0, 1'b1, 10, n);
		ok(n < 10);
		wait_sig(0, 1'b0, POR + 20, n);
		ok(n >= POR - 5 && n < POR + 20);
		$display("cmos supply test done");

		host_en <= 1'b0;
		ew_low <= 1'b1;
		wait_sig(1, 1'b0, 3 * 3300 + 400, n);
		ok(n >= 6600 && n < 3 * 3300 + 400);
		wait_sig(1, 1'b1, NP + 10, n);
		check(n, NP + 1);
		wait_sig(0, 1'b1, 200, n);
		check(n, 200);
		host_en <= 1'b1;
		wait_sig(1, 1'b0, 40, n);
		ok(n < 40);
		host_en <= 1'b0;
		ew_low <= 1'b0;
		$display("early warning test done");

		mode <= 1'b0;
		sleep_n <= 1'b0;
		wait_sig(2, 1'b1, 10, n);
		ok(n <= 4);
		wait_sig(0, 1'b1, 200, n);
		check(n, 200);
		sleep_n <= 1'b1;
		wait_sig(2, 1'b0, 10, n);
		ok(n <= 4);
		wait_sig(0, 1'b1, WD + 10, n);
		ok(n < WD + 10);
		$display("sleep test done");
		stop_test;
	end
endmodule
